// >>> common/fmpg_pkg.sv
// Purpose: constants for the fault mask and output-1 power-good tree block
// Assumes: 8-bit register port driven by the serial slave on the same clock
// Notes: reset values of all mask registers come from factory programming inputs
package fmpg_pkg;
	localparam int DATA_W = 8;
	localparam int ADDR_W = 8;

	// register offsets
	localparam logic [7:0] OFS_FAULT_MASK_FIRST = 8'hA2;
	localparam logic [7:0] OFS_FAULT_MASK_SECOND = 8'hA3;
	localparam logic [7:0] OFS_TREE_RAIL_MASK = 8'hA4;
	localparam logic [7:0] OFS_TREE_PIN_MASK = 8'hA5;

	// answer to an unmapped offset
	localparam logic [7:0] UNMAPPED_READ = 8'h00;

	// first fault mask fields
	localparam int FM1_AUX_LDO2 = 7;
	localparam int FM1_SWITCH_A1 = 6;
	localparam int FM1_STEP_DOWN6 = 5;
	localparam int FM1_STEP_DOWN1 = 0;

	// second fault mask fields
	localparam int FM2_RSVD_RO = 7;
	localparam int FM2_AUX_LDO1 = 4;
	localparam int FM2_TERMINATION = 3;
	localparam int FM2_SWITCH_B2 = 2;
	localparam int FM2_SWITCH_B1 = 1;
	localparam int FM2_AUX_LDO3 = 0;
	localparam int FM2_USED_W = 5;
	localparam logic [7:0] FM2_WRITABLE = 8'h7F;

	// output-1 tree rail mask fields
	localparam int TR_AUX_LDO2 = 7;
	localparam int TR_RSVD = 6;

	// output-1 tree pin mask fields
	localparam int TP_INPUT5 = 7;
	localparam int TP_INPUT4 = 6;
	localparam int TP_INPUT2 = 5;
	localparam int TP_INPUT1 = 4;
	localparam int TP_TERMINATION = 3;
	localparam int TP_RSVD_HI = 2;
	localparam int TP_RSVD_LO = 1;
	localparam int TP_AUX_LDO3 = 0;

	// reserved tree positions never take part in the AND
	localparam logic [7:0] TR_RSVD_MASK = 8'h40;
	localparam logic [7:0] TP_RSVD_MASK = 8'h06;
endpackage : fmpg_pkg

// >>> hdl/fmpg_sync.sv
// Purpose: two-stage synchroniser for a vector of pin-level inputs
// Assumes: inputs are slow levels, each bit crossing on its own
// Notes: first stage feeds only the second stage
`timescale 1ns/1ps
module fmpg_sync #(
	parameter int WIDTH = 8
) (
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta;

	// per-bit two flip-flop chain; reset to zero so faults start inactive
	genvar i;
	generate
		for (i = 0; i < WIDTH; i++)
		begin : g_bit
			always_ff @(posedge mclk)
			begin
				if (!reset_n)
				begin
					meta[i] <= 1'b0;
					sync_out[i] <= 1'b0;
				end
				else
				begin
					meta[i] <= async_in[i];
					sync_out[i] <= meta[i];
				end
			end
		end
	endgenerate
endmodule : fmpg_sync

// >>> hdl/fmpg_core.sv
// Purpose: power fault masking and output-1 power-good tree with its mask registers
// Assumes: register port comes from the serial slave in the mclk domain; status pins are asynchronous
// Notes: mask reset values load from factory programming inputs while reset_n is low
`timescale 1ns/1ps
module fmpg_core (
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic [7:0] otp_fault_mask_first,
	input wire logic [7:0] otp_fault_mask_second,
	input wire logic [7:0] otp_tree_rail_mask,
	input wire logic [7:0] otp_tree_pin_mask,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	output logic reg_rvalid,
	input wire logic [7:0] fault_first,
	input wire logic [4:0] fault_second,
	input wire logic [7:0] good_first,
	input wire logic termination_good,
	input wire logic aux_ldo3_good,
	input wire logic control_input_1,
	input wire logic control_input_2,
	input wire logic control_input_4,
	input wire logic control_input_5,
	output logic shutdown_req,
	output logic general_output_1
);
	logic [7:0] power_fault_mask_first;
	logic [7:0] power_fault_mask_second;
	logic [7:0] out1_good_tree_rail_mask;
	logic [7:0] out1_good_tree_pin_mask;
	logic [7:0] fault_first_s;
	logic [4:0] fault_second_s;
	logic [7:0] good_first_s;
	logic [5:0] pins_s;
	logic [7:0] pin_src;
	logic [12:0] fault_vec;
	logic [12:0] fault_msk;
	logic [12:0] fault_live;
	logic [15:0] tree_src;
	logic [15:0] tree_msk;
	logic [15:0] tree_ok;
	logic next_shutdown;
	logic next_good;
	// write enables and read mux input
	logic wr_fault_first;
	logic wr_fault_second;
	logic wr_tree_rail;
	logic wr_tree_pin;
	logic [7:0] next_rdata;

	// every status pin crosses through two flip-flops before use
	fmpg_sync #(.WIDTH(8)) u_sync_ff (
		.mclk(mclk),
		.reset_n(reset_n),
		.async_in(fault_first),
		.sync_out(fault_first_s)
	);
	fmpg_sync #(.WIDTH(5)) u_sync_fs (
		.mclk(mclk),
		.reset_n(reset_n),
		.async_in(fault_second),
		.sync_out(fault_second_s)
	);
	fmpg_sync #(.WIDTH(8)) u_sync_gf (
		.mclk(mclk),
		.reset_n(reset_n),
		.async_in(good_first),
		.sync_out(good_first_s)
	);
	fmpg_sync #(.WIDTH(6)) u_sync_pin (
		.mclk(mclk),
		.reset_n(reset_n),
		.async_in({control_input_5, control_input_4, control_input_2, control_input_1,
			termination_good, aux_ldo3_good}),
		.sync_out(pins_s)
	);

	// one write enable per register; unmapped offsets raise none, so those writes vanish
	assign wr_fault_first = reg_wr && (reg_addr == fmpg_pkg::OFS_FAULT_MASK_FIRST);
	assign wr_fault_second = reg_wr && (reg_addr == fmpg_pkg::OFS_FAULT_MASK_SECOND);
	assign wr_tree_rail = reg_wr && (reg_addr == fmpg_pkg::OFS_TREE_RAIL_MASK);
	assign wr_tree_pin = reg_wr && (reg_addr == fmpg_pkg::OFS_TREE_PIN_MASK);

	// first fault mask; synchronous reset so the factory value is legal to sample here
	always_ff @(posedge mclk)
	begin
		if (!reset_n)
		begin
			power_fault_mask_first <= otp_fault_mask_first;
		end
		else if (wr_fault_first)
		begin
			power_fault_mask_first <= reg_wdata;
		end
	end

	// second fault mask; reserved bits 6..5 are stored but never gate a fault
	always_ff @(posedge mclk)
	begin
		if (!reset_n)
		begin
			power_fault_mask_second <= otp_fault_mask_second;
		end
		else if (wr_fault_second)
		begin
			// bit 7 keeps its factory value: read-only reserved
			power_fault_mask_second <= (reg_wdata & fmpg_pkg::FM2_WRITABLE) |
				(power_fault_mask_second & ~fmpg_pkg::FM2_WRITABLE);
		end
	end

	// output-1 tree rail mask
	always_ff @(posedge mclk)
	begin
		if (!reset_n)
		begin
			out1_good_tree_rail_mask <= otp_tree_rail_mask;
		end
		else if (wr_tree_rail)
		begin
			out1_good_tree_rail_mask <= reg_wdata;
		end
	end

	// output-1 tree pin mask
	always_ff @(posedge mclk)
	begin
		if (!reset_n)
		begin
			out1_good_tree_pin_mask <= otp_tree_pin_mask;
		end
		else if (wr_tree_pin)
		begin
			out1_good_tree_pin_mask <= reg_wdata;
		end
	end

	// read mux sees the stored value, so a read in the write cycle returns the old one
	always_comb
	begin
		next_rdata = fmpg_pkg::UNMAPPED_READ;
		case (reg_addr)
			fmpg_pkg::OFS_FAULT_MASK_FIRST: next_rdata = power_fault_mask_first;
			fmpg_pkg::OFS_FAULT_MASK_SECOND: next_rdata = power_fault_mask_second;
			fmpg_pkg::OFS_TREE_RAIL_MASK: next_rdata = out1_good_tree_rail_mask;
			fmpg_pkg::OFS_TREE_PIN_MASK: next_rdata = out1_good_tree_pin_mask;
			default: next_rdata = fmpg_pkg::UNMAPPED_READ;
		endcase
	end

	// read answer one cycle after the strobe; data holds until the next read
	always_ff @(posedge mclk)
	begin
		if (!reset_n)
		begin
			reg_rdata <= 8'h00;
			reg_rvalid <= 1'b0;
		end
		else
		begin
			reg_rvalid <= reg_rd;
			if (reg_rd)
			begin
				reg_rdata <= next_rdata;
			end
		end
	end

	// pin tree sources in mask-bit order; reserved slots read as good
	assign pin_src = {pins_s[5:2], pins_s[1], 2'b11, pins_s[0]};

	// gather faults and their masks; reserved mask bits 7..5 take no part
	assign fault_vec = {fault_second_s, fault_first_s};
	assign fault_msk = {power_fault_mask_second[fmpg_pkg::FM2_USED_W-1:0], power_fault_mask_first};
	// reserved tree bits are forced to masked so their stored value changes nothing
	assign tree_src = {pin_src, good_first_s};
	assign tree_msk = {out1_good_tree_pin_mask | fmpg_pkg::TP_RSVD_MASK,
		out1_good_tree_rail_mask | fmpg_pkg::TR_RSVD_MASK};

	// per-source gating
	genvar k;
	generate
		for (k = 0; k < 13; k++)
		begin : g_fault
			assign fault_live[k] = fault_vec[k] & ~fault_msk[k];
		end
		for (k = 0; k < 16; k++)
		begin : g_tree
			assign tree_ok[k] = tree_src[k] | tree_msk[k];
		end
	endgenerate

	assign next_shutdown = |fault_live;
	assign next_good = &tree_ok;

	// outputs registered so they change once per clock, glitch free
	always_ff @(posedge mclk)
	begin
		if (!reset_n)
		begin
			shutdown_req <= 1'b0;
			general_output_1 <= 1'b0;
		end
		else
		begin
			shutdown_req <= next_shutdown;
			general_output_1 <= next_good;
		end
	end
endmodule : fmpg_core

// >>> tb/fmpg_monitor.sv
// Purpose: port assertions for fmpg_core
// Assumes: otp inputs constant
// Notes: pin paths take three edges
`timescale 1ns/1ps
module fmpg_monitor (
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic [7:0] otp_fault_mask_second,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic reg_rvalid,
	input wire logic [7:0] fault_first,
	input wire logic [4:0] fault_second,
	input wire logic shutdown_req,
	input wire logic general_output_1
);
	// one domain, reset aborts every check except reset_quiet_a
	default clocking @(posedge mclk);
	endclocking
	default disable iff (!reset_n);
	read_answer_a: assert property (reg_rd |=> reg_rvalid) else $error("no answer");
	answer_cause_a: assert property (reg_rvalid |-> $past(reg_rd)) else $error("stray answer");
	unmapped_zero_a: assert property (reg_rd && !(reg_addr inside {[8'hA2:8'hA5]}) |=> reg_rdata == 8'h00)
		else $error("unmapped data");
	locked_top_a: assert property (reg_rd && reg_addr == 8'hA3 |=> reg_rdata[7] == otp_fault_mask_second[7])
		else $error("read-only bit moved");
	reset_quiet_a: assert property (disable iff (1'b0) !reset_n |=> !shutdown_req && !general_output_1)
		else $error("active in reset");
	no_fault_a: assert property ((fault_first == 8'h00 && fault_second == 5'h00) [*3] |=> !shutdown_req)
		else $error("shutdown without fault");
	fault_cause_a: assert property ($rose(shutdown_req) |->
		{$past(fault_first, 3), $past(fault_second, 3)} != 13'h0000) else $error("shutdown cause");
	write_back_a: assert property (reg_wr && reg_addr inside {8'hA2, 8'hA4, 8'hA5} ##1 !reg_wr
		##1 reg_rd && !reg_wr && reg_addr == $past(reg_addr, 2) |=> reg_rdata == $past(reg_wdata, 3))
		else $error("write lost");
endmodule : fmpg_monitor

bind fmpg_core fmpg_monitor u_mon (
	.mclk(mclk), .reset_n(reset_n), .otp_fault_mask_second(otp_fault_mask_second),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .fault_first(fault_first),
	.fault_second(fault_second), .shutdown_req(shutdown_req), .general_output_1(general_output_1)
);

// >>> tb/fmpg_host.sv
// Purpose: host model on the register port
// Assumes: tasks entered just after a falling edge
// Notes: strobes last one cycle, then one idle edge passes before the next call
`timescale 1ns/1ps
module fmpg_host (
	input wire logic mclk,
	input wire logic [7:0] reg_rdata,
	input wire logic reg_rvalid,
	output logic [7:0] reg_addr = 8'h00,
	output logic [7:0] reg_wdata = 8'h00,
	output logic reg_wr = 1'b0,
	output logic reg_rd = 1'b0
);
	// write: strobe for one edge; the idle edge after it keeps a following call from re-driving the strobe
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge mclk);
		reg_wr = 1'b0;
		@(negedge mclk);
	endtask : wr
	// read: data taken while the answer stands; a missing valid shows up as unknown data
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge mclk);
		reg_rd = 1'b0;
		d = reg_rvalid ? reg_rdata : 8'hXX;
		@(negedge mclk);
	endtask : rd
endmodule : fmpg_host

// >>> tb/fmpg_core_tb_top.sv
// Purpose: self-checking bench for fmpg_core
// Assumes: otp values fixed all run
// Notes: pins reach outputs three edges late
`timescale 1ns/1ps
module fmpg_core_tb_top;
	logic mclk = 1'b0;
	logic reset_n = 1'b0;
	logic [12:0] fault = 13'h0000;
	logic [15:0] good = 16'hFFFF;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, rd_val;
	logic reg_wr, reg_rd, reg_rvalid, shutdown_req, general_output_1;
	int fail_count = 0;
	int cmp_count = 0;
	int cycles = 0;
	always #4 mclk = ~mclk;
	// good bits 9 and 10 sit on reserved tree slots
	fmpg_core dut (
		.mclk(mclk), .reset_n(reset_n), .otp_fault_mask_first(8'hC0), .otp_fault_mask_second(8'hA6),
		.otp_tree_rail_mask(8'hFF), .otp_tree_pin_mask(8'hFF), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
		.fault_first(fault[7:0]), .fault_second(fault[12:8]), .good_first(good[7:0]),
		.termination_good(good[11]), .aux_ldo3_good(good[8]), .control_input_1(good[12]),
		.control_input_2(good[13]), .control_input_4(good[14]), .control_input_5(good[15]),
		.shutdown_req(shutdown_req), .general_output_1(general_output_1)
	);
	fmpg_host host (
		.mclk(mclk), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd)
	);
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			fail_count++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask : check
	task automatic check_rd(input logic [7:0] a, input logic [7:0] exp);
		host.rd(a, rd_val);
		check(rd_val, exp);
	endtask : check_rd
	task automatic stop_test;
		if (fail_count == 0 && cmp_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : stop_test
	// hang guard, tests need well under a thousand cycles
	always @(posedge mclk)
	begin
		cycles++;
		if (cycles == 2000)
		begin
			fail_count++;
			stop_test();
		end
	end
	// reset, register map, each fault and tree source in turn, then a reset in mid-run
	initial
	begin
		repeat (4) @(negedge mclk);
		reset_n = 1'b1;
		@(negedge mclk);
		check_rd(8'hA2, 8'hC0);
		check_rd(8'hA3, 8'hA6);
		check_rd(8'hA4, 8'hFF);
		check_rd(8'hA5, 8'hFF);
		check_rd(8'hA6, 8'h00);
		host.wr(8'hA2, 8'h3C);
		check_rd(8'hA2, 8'h3C);
		// the one deliberate probe: bit 7 written low, bits 6..5 rewritten as they stand
		host.wr(8'hA3, 8'h3C);
		check_rd(8'hA3, 8'hBC);
		host.wr(8'hA4, 8'h7C);
		check_rd(8'hA4, 8'h7C);
		host.wr(8'hA5, 8'h3E);
		check_rd(8'hA5, 8'h3E);
		// every source live; reserved bits keep what they hold
		host.wr(8'hA2, 8'h00);
		host.wr(8'hA3, 8'hA0);
		host.wr(8'hA4, 8'h40);
		host.wr(8'hA5, 8'h06);
		check_rd(8'hA3, 8'hA0);
		for (int i = 0; i < 13; i++)
		begin
			fault[i] = 1'b1;
			repeat (4) @(negedge mclk);
			check({7'h00, shutdown_req}, 8'h01);
			host.wr(i < 8 ? 8'hA2 : 8'hA3, i < 8 ? 8'h01 << i : 8'hA0 | (8'h01 << (i - 8)));
			@(negedge mclk);
			check({7'h00, shutdown_req}, 8'h00);
			host.wr(i < 8 ? 8'hA2 : 8'hA3, i < 8 ? 8'h00 : 8'hA0);
			fault[i] = 1'b0;
		end
		for (int i = 0; i < 16; i++)
		begin
			good[i] = 1'b0;
			repeat (4) @(negedge mclk);
			check({7'h00, general_output_1}, {7'h00, i inside {6, 9, 10}});
			host.wr(i < 8 ? 8'hA4 : 8'hA5, i < 8 ? 8'h40 | (8'h01 << i) : 8'h06 | (8'h01 << (i - 8)));
			@(negedge mclk);
			check({7'h00, general_output_1}, 8'h01);
			host.wr(i < 8 ? 8'hA4 : 8'hA5, i < 8 ? 8'h40 : 8'h06);
			good[i] = 1'b1;
		end
		// a reset in mid-run brings the factory values back over the written ones
		reset_n = 1'b0;
		repeat (2) @(negedge mclk);
		reset_n = 1'b1;
		@(negedge mclk);
		check_rd(8'hA2, 8'hC0);
		check_rd(8'hA5, 8'hFF);
		stop_test();
	end
endmodule : fmpg_core_tb_top
